/* design/ssr_regs.svh */
// register offsets, field values and timing constants for speed step select
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define SSR_ADDR_REF_SRC      16'h0180
`define SSR_ADDR_RUN_SRC      16'h0181
`define SSR_ADDR_STORED_BASE  16'h0280
`define SSR_ADDR_STORED_LAST  16'h0287
`define SSR_ADDR_JOG_FREQ     16'h0290
`define SSR_ADDR_THIRD_FUNC   16'h0300
`define SSR_ADDR_SECOND_FUNC  16'h0301
`define SSR_ADDR_MI_BASE      16'h0310
`define SSR_ADDR_MI_LAST      16'h0315
`define SSR_ADDR_INIT         16'h0320
`define SSR_ADDR_STATUS       16'h0330

// ****************************************
// reset values and limits
// ****************************************
`define SSR_REF_SRC_RST       16'h0001
`define SSR_RUN_SRC_RST       16'h0001
`define SSR_REF_SRC_MAX       16'h0004
`define SSR_RUN_SRC_MAX       16'h0003
`define SSR_ANA_FUNC_RST      16'h000F
`define SSR_ZERO16            16'h0000

// ****************************************
// function codes
// ****************************************
`define SSR_FN_THREE_WIRE     8'h00
`define SSR_FN_STEP0          8'h03
`define SSR_FN_STEP1          8'h04
`define SSR_FN_STEP2          8'h05
`define SSR_FN_JOG            8'h06
`define SSR_FN_UNUSED         8'h0F
`define SSR_ANA_AUX1          16'h0002
`define SSR_ANA_AUX2          16'h0003
`define SSR_INIT_TWO_WIRE     16'h0001
`define SSR_INIT_THREE_WIRE   16'h0002
`define SSR_MI_DIR_INIT_IDX   3'h2

// ****************************************
// input bit positions
// ****************************************
`define SSR_IN_FWD            0
`define SSR_IN_REV            1
`define SSR_IN_MI_LO          2
`define SSR_IN_WIDTH          8
`define SSR_MI_COUNT          6

// ****************************************
// timing
// ****************************************
`define SSR_CLK_KHZ           40000
`define SSR_DEB_TIME_MS       1
`define SSR_DEB_CYCLES        (`SSR_DEB_TIME_MS * `SSR_CLK_KHZ)

`endif

/* design/ssr_pkg.sv */
// types shared by the speed step select design
package ssr_pkg;

  typedef enum logic [1:0] {
    SSR_SRC_KEYPAD,
    SSR_SRC_TERMINAL,
    SSR_SRC_SERIAL,
    SSR_SRC_OPTION
  } ssr_run_src_t;

  typedef enum logic [1:0] {
    SSR_ST_IDLE,
    SSR_ST_RUN
  } ssr_run_state_t;

endpackage

/* design/ssr_in_if.sv */
// carrier for raw and filtered contact inputs
`timescale 1ns/1ps
`default_nettype none
interface ssr_in_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

/* design/ssr_debounce.sv */
// synchroniser and debounce filter for the contact inputs
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"
module ssr_debounce #(
  parameter int DEB_CYCLES = `SSR_DEB_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // inputs
  ssr_in_if.filt    pins
);

  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;
  logic [7:0]  clean_q;
  logic [15:0] cnt_q [0:7];

  // ****************************************
  // synchroniser
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pins.raw;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // stability filter
  // ****************************************
  // a level must stand unchanged for the whole window before it passes
  always_ff @(posedge clk) begin
    if (reset) begin
      clean_q <= 8'h00;
      for (int i = 0; i < 8; i++) cnt_q[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sync2_q[i] == clean_q[i]) begin
          cnt_q[i] <= 16'h0000;
        end else if (cnt_q[i] == 16'(DEB_CYCLES - 1)) begin
          cnt_q[i]   <= 16'h0000;
          clean_q[i] <= sync2_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  assign pins.clean = clean_q;

endmodule
`default_nettype wire

/* design/ssr_top.sv */
// speed step select and run command source logic of a motor drive
//
// Behaviour
// - jog off: reference N+1 from step bits, all off 1, all on 8
// - jog input on: jog frequency wins regardless of step bits
// - step 1: first analog if reference source 1, stored 1 if 0
// - step 2: analog with function 2 is aux 1, else stored 2
// - step 3: analog with function 3 is aux 2, else stored 3
// - both analog function settings never equal; such a write refused
// - run source 0: run, stop, jog, direction from keypad keys
// - two-wire: forward input on runs forward, off stops
// - two-wire: reverse input on runs reverse, off stops
// - any multi input function 0 selects three-wire, that input is direction
// - three-wire initialise puts direction on multi_in[2]
// - three-wire: accepted run pulse latched after release
// - reference source takes 0..4
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"
module ssr_top #(
  parameter int DEB_CYCLES = `SSR_DEB_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // contact inputs
  input  wire logic        forward_run_input,
  input  wire logic        reverse_stop_input,
  input  wire logic [5:0]  multi_in,
  // analog inputs
  input  wire logic [15:0] analog_in_first,
  input  wire logic [15:0] analog_in_second,
  input  wire logic [15:0] analog_in_third,
  // keypad keys
  input  wire logic        key_run,
  input  wire logic        key_stop,
  input  wire logic        key_jog,
  input  wire logic        key_dir,
  // serial / option run command
  input  wire logic        comm_run,
  input  wire logic        comm_reverse,
  // parameter port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  output logic      [15:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // results
  output logic      [15:0] freq_ref,
  output logic      [3:0]  speed_step,
  output logic             run_cmd,
  output logic             reverse_cmd,
  output logic             jog_cmd,
  output logic             three_wire
);

  // ****************************************
  // declarations
  // ****************************************
  ssr_in_if in_bus ();
  ssr_pkg::ssr_run_state_t state_q;
  logic [15:0] ref_src_q;
  logic [15:0] run_src_q;
  logic [15:0] third_fn_q;
  logic [15:0] second_fn_q;
  logic [15:0] stored_q [0:8];
  logic [7:0]  mi_fn_q [0:5];
  logic [15:0] par_rdata_q;
  logic        par_ack_q;
  logic        par_err_q;
  logic [15:0] freq_q;
  logic [3:0]  step_q;
  logic        run_q;
  logic        rev_q;
  logic        jog_q;
  logic        fwd_prev_q;
  logic        key_run_q;
  logic        key_rev_q;
  logic        three_w;
  logic        dir_in;
  logic        jog_in;
  logic [2:0]  step_bits;
  logic [15:0] step_ref;
  logic        wr_ok;
  logic        hit;
  logic [15:0] rd_val;
  ssr_pkg::ssr_run_src_t run_src;

  // ****************************************
  // input filter
  // ****************************************
  assign in_bus.raw = {multi_in, reverse_stop_input, forward_run_input};

  ssr_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
    .clk   (clk),
    .reset (reset),
    .pins  (in_bus.filt)
  );

  // OR of every filtered multi input whose function equals code
  function automatic logic mi_any(input logic [7:0] code,
                                  input logic [7:0] clean);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `SSR_MI_COUNT; i++)
      if (mi_fn_q[i] == code) r = r | clean[i + `SSR_IN_MI_LO];
    return r;
  endfunction

  function automatic logic mi_set(input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `SSR_MI_COUNT; i++)
      if (mi_fn_q[i] == code) r = 1'b1;
    return r;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    three_w   = mi_set(`SSR_FN_THREE_WIRE);
    dir_in    = mi_any(`SSR_FN_THREE_WIRE, in_bus.clean);
    jog_in    = mi_any(`SSR_FN_JOG, in_bus.clean);
    step_bits = {mi_any(`SSR_FN_STEP2, in_bus.clean),
                 mi_any(`SSR_FN_STEP1, in_bus.clean),
                 mi_any(`SSR_FN_STEP0, in_bus.clean)};
    run_src   = ssr_pkg::ssr_run_src_t'(run_src_q[1:0]);
    case (step_bits)
      3'h0: step_ref = (ref_src_q == `SSR_REF_SRC_RST) ? analog_in_first
                       : stored_q[0];
      3'h1: step_ref = (second_fn_q == `SSR_ANA_AUX1) ? analog_in_second
                     : (third_fn_q == `SSR_ANA_AUX1) ? analog_in_third
                     : stored_q[1];
      3'h2: step_ref = (third_fn_q == `SSR_ANA_AUX2) ? analog_in_third
                     : (second_fn_q == `SSR_ANA_AUX2) ? analog_in_second
                     : stored_q[2];
      default: step_ref = stored_q[step_bits];
    endcase
  end

  // ****************************************
  // reference select
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_q <= `SSR_ZERO16;
      step_q <= 4'h1;
    end else if (jog_q) begin
      freq_q <= stored_q[8];
      step_q <= 4'h9;
    end else begin
      freq_q <= step_ref;
      step_q <= {1'b0, step_bits} + 4'h1;
    end
  end

  // ****************************************
  // run command
  // ****************************************
  // keypad stop beats a simultaneous run key, for safety
  always_ff @(posedge clk) begin
    if (reset) begin
      key_run_q <= 1'b0;
      key_rev_q <= 1'b0;
    end else begin
      if (key_stop) key_run_q <= 1'b0;
      else if (key_run) key_run_q <= 1'b1;
      if (key_dir) key_rev_q <= ~key_rev_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ssr_pkg::SSR_ST_IDLE;
      fwd_prev_q <= 1'b0;
    end else begin
      fwd_prev_q <= in_bus.clean[`SSR_IN_FWD];
      case (state_q)
        ssr_pkg::SSR_ST_IDLE:
          if (three_w && in_bus.clean[`SSR_IN_FWD] && !fwd_prev_q
              && in_bus.clean[`SSR_IN_REV])
            state_q <= ssr_pkg::SSR_ST_RUN;
        ssr_pkg::SSR_ST_RUN:
          if (!three_w || !in_bus.clean[`SSR_IN_REV])
            state_q <= ssr_pkg::SSR_ST_IDLE;
        default: state_q <= ssr_pkg::SSR_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      run_q <= 1'b0;
      rev_q <= 1'b0;
      jog_q <= 1'b0;
    end else begin
      case (run_src)
        ssr_pkg::SSR_SRC_KEYPAD: begin
          run_q <= key_run_q | key_jog;
          rev_q <= key_rev_q;
          jog_q <= key_jog | jog_in;
        end
        ssr_pkg::SSR_SRC_TERMINAL: begin
          jog_q <= jog_in;
          if (three_w) begin
            run_q <= (state_q == ssr_pkg::SSR_ST_RUN);
            rev_q <= dir_in;
          end else begin
            // both contacts closed is treated as stop
            run_q <= in_bus.clean[`SSR_IN_FWD]
                     ^ in_bus.clean[`SSR_IN_REV];
            rev_q <= in_bus.clean[`SSR_IN_REV];
          end
        end
        default: begin
          run_q <= comm_run;
          rev_q <= comm_reverse;
          jog_q <= jog_in;
        end
      endcase
    end
  end

  // ****************************************
  // parameter writes
  // ****************************************
  always_comb begin
    hit   = 1'b1;
    wr_ok = 1'b0;
    rd_val = `SSR_ZERO16;
    if (par_addr == `SSR_ADDR_REF_SRC) begin
      rd_val = ref_src_q;
      wr_ok  = par_wdata <= `SSR_REF_SRC_MAX;
    end else if (par_addr == `SSR_ADDR_RUN_SRC) begin
      rd_val = run_src_q;
      wr_ok  = par_wdata <= `SSR_RUN_SRC_MAX;
    end else if (par_addr >= `SSR_ADDR_STORED_BASE
                 && par_addr <= `SSR_ADDR_STORED_LAST) begin
      rd_val = stored_q[par_addr[2:0]];
      wr_ok  = 1'b1;
    end else if (par_addr == `SSR_ADDR_JOG_FREQ) begin
      rd_val = stored_q[8];
      wr_ok  = 1'b1;
    end else if (par_addr == `SSR_ADDR_THIRD_FUNC) begin
      rd_val = third_fn_q;
      wr_ok  = par_wdata != second_fn_q;
    end else if (par_addr == `SSR_ADDR_SECOND_FUNC) begin
      rd_val = second_fn_q;
      wr_ok  = par_wdata != third_fn_q;
    end else if (par_addr >= `SSR_ADDR_MI_BASE
                 && par_addr <= `SSR_ADDR_MI_LAST) begin
      rd_val = {8'h00, mi_fn_q[par_addr[2:0]]};
      wr_ok  = par_wdata[15:8] == 8'h00;
    end else if (par_addr == `SSR_ADDR_INIT) begin
      wr_ok  = par_wdata == `SSR_INIT_TWO_WIRE
               || par_wdata == `SSR_INIT_THREE_WIRE;
    end else if (par_addr == `SSR_ADDR_STATUS) begin
      rd_val = {9'h000, three_w, jog_q, rev_q, run_q, 3'h0};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_src_q   <= `SSR_REF_SRC_RST;
      run_src_q   <= `SSR_RUN_SRC_RST;
      third_fn_q  <= `SSR_ANA_FUNC_RST;
      second_fn_q <= `SSR_ZERO16;
      for (int i = 0; i < 9; i++) stored_q[i] <= `SSR_ZERO16;
      mi_fn_q[0] <= `SSR_FN_UNUSED;
      mi_fn_q[1] <= `SSR_FN_UNUSED;
      mi_fn_q[2] <= `SSR_FN_STEP0;
      mi_fn_q[3] <= `SSR_FN_STEP1;
      mi_fn_q[4] <= `SSR_FN_STEP2;
      mi_fn_q[5] <= `SSR_FN_JOG;
    end else if (par_wr && hit && wr_ok) begin
      if (par_addr == `SSR_ADDR_REF_SRC) ref_src_q <= par_wdata;
      if (par_addr == `SSR_ADDR_RUN_SRC) run_src_q <= par_wdata;
      if (par_addr >= `SSR_ADDR_STORED_BASE
          && par_addr <= `SSR_ADDR_STORED_LAST)
        stored_q[par_addr[2:0]] <= par_wdata;
      if (par_addr == `SSR_ADDR_JOG_FREQ) stored_q[8] <= par_wdata;
      if (par_addr == `SSR_ADDR_THIRD_FUNC) third_fn_q <= par_wdata;
      if (par_addr == `SSR_ADDR_SECOND_FUNC) second_fn_q <= par_wdata;
      if (par_addr >= `SSR_ADDR_MI_BASE && par_addr <= `SSR_ADDR_MI_LAST)
        mi_fn_q[par_addr[2:0]] <= par_wdata[7:0];
      if (par_addr == `SSR_ADDR_INIT) begin
        // initialise restores terminal roles; settings elsewhere kept
        mi_fn_q[0] <= `SSR_FN_UNUSED;
        mi_fn_q[1] <= `SSR_FN_UNUSED;
        mi_fn_q[2] <= (par_wdata == `SSR_INIT_THREE_WIRE)
                      ? `SSR_FN_THREE_WIRE : `SSR_FN_STEP0;
        mi_fn_q[3] <= `SSR_FN_STEP1;
        mi_fn_q[4] <= `SSR_FN_STEP2;
        mi_fn_q[5] <= `SSR_FN_JOG;
      end
    end
  end

  // ****************************************
  // parameter answers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      par_rdata_q <= `SSR_ZERO16;
      par_ack_q   <= 1'b0;
      par_err_q   <= 1'b0;
    end else begin
      par_ack_q   <= par_wr | par_rd;
      par_err_q   <= (par_wr & ~(hit & wr_ok)) | (par_rd & ~hit);
      par_rdata_q <= (par_rd && !par_wr) ? rd_val : `SSR_ZERO16;
    end
  end

  assign par_rdata   = par_rdata_q;
  assign par_ack     = par_ack_q;
  assign par_err     = par_err_q;
  assign freq_ref    = freq_q;
  assign speed_step  = step_q;
  assign run_cmd     = run_q;
  assign reverse_cmd = rev_q;
  assign jog_cmd     = jog_q;
  assign three_wire  = three_w;

endmodule
`default_nettype wire

/* tb/ssr_top_props.sv */
// port assertions for the speed step select block
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"
module ssr_top_props (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // parameter port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  input  wire logic [15:0] par_rdata,
  input  wire logic        par_ack,
  input  wire logic        par_err,
  // results
  input  wire logic [15:0] freq_ref,
  input  wire logic [3:0]  speed_step,
  input  wire logic        run_cmd
);
  // ****************
  // helpers
  // ****************
  logic run_wr;
  logic ref_wr;
  assign run_wr = par_wr && par_addr == `SSR_ADDR_RUN_SRC;
  assign ref_wr = par_wr && par_addr == `SSR_ADDR_REF_SRC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ****************
  // properties
  // ****************
  a_ack_follows: assert property ((par_wr || par_rd) |=> par_ack)
    else $error("no ack one cycle after strobe");
  a_ack_cause: assert property (par_ack |-> $past(par_wr) || $past(par_rd))
    else $error("ack without strobe");
  a_err_with_ack: assert property (par_err |-> par_ack)
    else $error("err outside ack");
  a_rdata_idle: assert property (!par_ack |-> par_rdata == 16'h0000)
    else $error("read data outside ack");
  a_run_src_bad: assert property (
    run_wr && par_wdata > `SSR_RUN_SRC_MAX |=> par_err)
    else $error("run source overrange accepted");
  a_run_src_good: assert property (
    run_wr && par_wdata <= `SSR_RUN_SRC_MAX |=> !par_err)
    else $error("run source in range refused");
  a_ref_src_bad: assert property (
    ref_wr && par_wdata > `SSR_REF_SRC_MAX |=> par_err)
    else $error("reference source overrange accepted");
  a_step_range: assert property (
    speed_step >= 4'h1 && speed_step <= 4'h9)
    else $error("step out of range");
  // reset itself is the cause here, so it cannot also disable the check
  a_reset_state: assert property (disable iff (1'b0) reset |=>
    speed_step == 4'h1 && !run_cmd && freq_ref == 16'h0000)
    else $error("outputs not at reset state");
endmodule
`default_nettype wire

/* tb/ssr_field_model.sv */
// field contacts that chatter before settling
`timescale 1ns/1ps
`default_nettype none
module ssr_field_model (
  // clock
  input  wire logic       clk,
  // wanted and delivered contact levels
  input  wire logic [7:0] want,
  output logic      [7:0] pins
);
  logic [7:0] last_q;
  logic [7:0] old_q;
  logic [1:0] bnc_q;
  initial begin
    last_q = 8'h00;
    old_q  = 8'h00;
    bnc_q  = 2'h0;
    pins   = 8'h00;
  end
  // chatter lasts two cycles, inside the filter window
  always @(negedge clk) begin
    if (want !== last_q) begin
      old_q  <= last_q;
      last_q <= want;
      bnc_q  <= 2'h2;
      pins   <= want;
    end else if (bnc_q != 2'h0) begin
      bnc_q <= bnc_q - 2'h1;
      pins  <= bnc_q[1] ? old_q : want;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the speed step select block
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"
module tb;
  logic        clk, reset, par_wr, par_rd, par_ack, par_err;
  logic        key_run, key_stop, key_jog, key_dir, comm_run, comm_rev;
  logic        run_cmd, reverse_cmd, jog_cmd, three_wire, seen;
  logic [7:0]  cont, pins;
  logic [3:0]  speed_step;
  logic [15:0] par_addr, par_wdata, par_rdata, freq_ref;
  int          n_mismatch, tests_run, i;

  ssr_field_model i_ssr_field_model (.clk(clk), .want(cont), .pins(pins));
  ssr_top #(.DEB_CYCLES(4)) i_ssr_top (
    .clk(clk), .reset(reset),
    .forward_run_input(pins[0]), .reverse_stop_input(pins[1]),
    .multi_in(pins[7:2]), .analog_in_first(16'h1111),
    .analog_in_second(16'h2222), .analog_in_third(16'h3333),
    .key_run(key_run), .key_stop(key_stop), .key_jog(key_jog),
    .key_dir(key_dir), .comm_run(comm_run), .comm_reverse(comm_rev),
    .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_err(par_err), .freq_ref(freq_ref), .speed_step(speed_step),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .jog_cmd(jog_cmd),
    .three_wire(three_wire));

  // ****************
  // tasks
  // ****************
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // strobe held across the taking edge, answer read one cycle on
  task automatic par_io(logic w, logic [15:0] a, logic [15:0] d,
                        logic [15:0] x, logic e);
    @(negedge clk);
    par_wr = w;
    par_rd = !w;
    par_addr = a;
    par_wdata = d;
    @(negedge clk);
    par_wr = 1'b0;
    par_rd = 1'b0;
    check("ack", 16'h0001, {15'h0000, par_ack});
    check("err", {15'h0000, e}, {15'h0000, par_err});
    if (!w) begin
      check("rdata", x, par_rdata);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d, logic e);
    par_io(1'b1, a, d, 16'h0000, e);
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] x);
    par_io(1'b0, a, 16'h0000, x, 1'b0);
  endtask
  task automatic settle(logic [3:0] st, logic [15:0] fr, logic rn, logic rv);
    int k;
    for (k = 0; k < 40 && !(speed_step === st && run_cmd === rn &&
         reverse_cmd === rv); k++) begin
      @(negedge clk);
    end
    if (k == 40) begin
      check("settle timeout", 16'h0001, 16'h0000);
      wrap_up();
    end else begin
      check("step", {12'h000, st}, {12'h000, speed_step});
      check("freq", fr, freq_ref);
      check("run", {15'h0000, rn}, {15'h0000, run_cmd});
      check("reverse", {15'h0000, rv}, {15'h0000, reverse_cmd});
    end
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {reset, par_wr, par_rd, key_run, key_stop, key_jog} = 6'h20;
    {key_dir, comm_run, comm_rev, seen, cont, par_addr, par_wdata} = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    rd(`SSR_ADDR_RUN_SRC, `SSR_RUN_SRC_RST);
    rd(`SSR_ADDR_REF_SRC, `SSR_REF_SRC_RST);
    for (i = 0; i < 5; i++) begin
      wr(`SSR_ADDR_RUN_SRC, i[15:0], i == 4);
    end
    rd(`SSR_ADDR_RUN_SRC, 16'h0003);
    wr(`SSR_ADDR_REF_SRC, 16'h0005, 1'b1);
    wr(`SSR_ADDR_REF_SRC, 16'h0004, 1'b0);
    rd(`SSR_ADDR_REF_SRC, 16'h0004);
    wr(`SSR_ADDR_REF_SRC, 16'h0000, 1'b0);
    for (i = 0; i < 8; i++) begin
      wr(`SSR_ADDR_STORED_BASE + i[15:0], 16'h0100 + i[15:0], 1'b0);
    end
    wr(`SSR_ADDR_JOG_FREQ, 16'h0aaa, 1'b0);
    for (i = 0; i < 8; i++) begin
      cont = {1'b0, i[2:0], 4'h0};
      settle(i[3:0] + 4'h1, 16'h0100 + i[15:0], 1'b0, 1'b0);
    end
    cont = 8'hf0;
    settle(4'h9, 16'h0aaa, 1'b0, 1'b0);
    wr(`SSR_ADDR_REF_SRC, 16'h0001, 1'b0);
    cont = 8'h00;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    wr(`SSR_ADDR_SECOND_FUNC, `SSR_ANA_AUX1, 1'b0);
    wr(`SSR_ADDR_THIRD_FUNC, `SSR_ANA_AUX2, 1'b0);
    cont = 8'h10;
    settle(4'h2, 16'h2222, 1'b0, 1'b0);
    cont = 8'h20;
    settle(4'h3, 16'h3333, 1'b0, 1'b0);
    wr(`SSR_ADDR_THIRD_FUNC, `SSR_ANA_AUX1, 1'b1);
    wr(`SSR_ADDR_SECOND_FUNC, `SSR_ANA_AUX2, 1'b1);
    rd(`SSR_ADDR_THIRD_FUNC, `SSR_ANA_AUX2);
    par_io(1'b0, 16'h0500, 16'h0000, 16'h0000, 1'b1);
    wr(`SSR_ADDR_STATUS, 16'h0000, 1'b1);
    wr(`SSR_ADDR_RUN_SRC, 16'h0001, 1'b0);
    cont = 8'h01;
    settle(4'h1, 16'h1111, 1'b1, 1'b0);
    cont = 8'h00;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    cont = 8'h02;
    settle(4'h1, 16'h1111, 1'b1, 1'b1);
    cont = 8'h00;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    // a pulse shorter than the filter window must never reach the run flag
    cont = 8'h01;
    repeat (2) @(negedge clk);
    cont = 8'h00;
    seen = 1'b0;
    repeat (16) begin
      @(negedge clk);
      seen = seen | run_cmd;
    end
    check("glitch run", 16'h0000, {15'h0000, seen});
    wr(`SSR_ADDR_INIT, `SSR_INIT_THREE_WIRE, 1'b0);
    check("three wire", 16'h0001, {15'h0000, three_wire});
    rd(`SSR_ADDR_MI_BASE + 16'h0002, 16'h0000);
    cont = 8'h02;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    cont = 8'h03;
    settle(4'h1, 16'h1111, 1'b1, 1'b0);
    cont = 8'h02;
    repeat (16) @(negedge clk);
    settle(4'h1, 16'h1111, 1'b1, 1'b0);
    cont = 8'h12;
    settle(4'h1, 16'h1111, 1'b1, 1'b1);
    cont = 8'h00;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    wr(`SSR_ADDR_INIT, `SSR_INIT_TWO_WIRE, 1'b0);
    check("three wire", 16'h0000, {15'h0000, three_wire});
    wr(`SSR_ADDR_RUN_SRC, 16'h0000, 1'b0);
    key_run = 1'b1;
    @(negedge clk);
    key_run = 1'b0;
    settle(4'h1, 16'h1111, 1'b1, 1'b0);
    key_stop = 1'b1;
    @(negedge clk);
    key_stop = 1'b0;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    key_dir = 1'b1;
    @(negedge clk);
    key_dir = 1'b0;
    settle(4'h1, 16'h1111, 1'b0, 1'b1);
    key_dir = 1'b1;
    @(negedge clk);
    key_dir = 1'b0;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    key_jog = 1'b1;
    settle(4'h9, 16'h0aaa, 1'b1, 1'b0);
    check("jog", 16'h0001, {15'h0000, jog_cmd});
    key_jog = 1'b0;
    wr(`SSR_ADDR_RUN_SRC, 16'h0002, 1'b0);
    comm_run = 1'b1;
    settle(4'h1, 16'h1111, 1'b1, 1'b0);
    comm_rev = 1'b1;
    settle(4'h1, 16'h1111, 1'b1, 1'b1);
    comm_rev = 1'b0;
    comm_run = 1'b0;
    settle(4'h1, 16'h1111, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

bind ssr_top ssr_top_props i_ssr_top_props (
  .clk(clk), .reset(reset), .par_wr(par_wr), .par_rd(par_rd),
  .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
  .par_ack(par_ack), .par_err(par_err), .freq_ref(freq_ref),
  .speed_step(speed_step), .run_cmd(run_cmd));
`default_nettype wire
